/* File: verilog/nv_host_pkg.sv */
`default_nettype none
package nv_host_pkg;

  // Clock and array geometry
  localparam int CLK_NS      = 10;
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int CNT_W       = 20;
  localparam int SEQ_LEN     = 6;

  // Timing figures of the slowest speed grade
  localparam int T_ACCESS_NS  = 45;
  localparam int T_WRPULSE_NS = 45;
  localparam int T_SEQPULSE_NS = 35;
  localparam int T_GAP_NS     = 45;
  localparam int T_RESTORE_US = 20;
  localparam int T_SAVE_MS    = 10;
  localparam int T_PWRUP_US   = 650;
  localparam int SYNC_STAGES  = 2;

  // Cycle counts derived from the figures, waits rounded up
  localparam int RD_CYC      = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int WR_CYC      = (T_WRPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEQ_CYC     = (T_SEQPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTORE_CYC = (T_RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_CYC_DEF = (T_SAVE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC_DEF = (T_PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Unlock address sequence
  localparam logic [ADDR_W-1:0] SEQ_P0      = 13'h0000;
  localparam logic [ADDR_W-1:0] SEQ_P1      = 13'h1555;
  localparam logic [ADDR_W-1:0] SEQ_P2      = 13'h0AAA;
  localparam logic [ADDR_W-1:0] SEQ_P3      = 13'h1FFF;
  localparam logic [ADDR_W-1:0] SEQ_P4      = 13'h10F0;
  localparam logic [ADDR_W-1:0] SEQ_SAVE    = 13'h0F0F;
  localparam logic [ADDR_W-1:0] SEQ_RESTORE = 13'h0F0E;
  localparam logic [ADDR_W-1:0] SEQ_TEST    = 13'h139C;
  localparam logic [2:0]        SEQ_LAST    = 3'h5;

  // Reset values of the pins
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_WRITE   = 2'h1,
    OP_SAVE    = 2'h2,
    OP_RESTORE = 2'h3
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_IDLE    = 3'h1,
    ST_READ    = 3'h2,
    ST_WRITE   = 3'h3,
    ST_GAP     = 3'h4,
    ST_UNLOCK  = 3'h5,
    ST_NV_WAIT = 3'h6
  } state_t;

endpackage
`default_nettype wire

/* File: verilog/nv_host_ctrl.sv */
// Summary of operation
// [R1] Write strobe stays high while chip select is low in unlock steps.
// [R2] Unlock recognition ignores output enable level.
// [R3] Sixth unlock address alone picks save or restore.
// [R4] Every unlock step is its own chip-select read pulse.
// [R5] Chip select and output enable low, write high reads one byte.
// [R6] Read outputs track address and stay valid until a strobe changes.
// [R7] Write while select and write low; address held; first rising ends.
// [R8] Device turns drivers off soon after write falls with output enabled.
// [R9] Output enable held high for whole write cycle.
// [R10] Device saves automatically when supply falls below threshold.
// [R11] Automatic save only if written since last save or restore.
// [R12] Software save always runs, written or not.
// [R13] Device restores once supply rises again after low supply.
// [R14] Never leave the device in a write state at power-up restore end.
// [R15] Save sequence: 0000,1555,0AAA,1FFF,10F0,0F0F as consecutive reads.
// [R16] No other access between unlock steps; partial progress is lost.
// [R17] Restore sequence: same five reads then 0F0E.
// [R18] After sixth address the chip is disabled until cycle time elapses.
// [R19] Save erases then programs all nonvolatile cells from SRAM.
// [R20] Restore clears SRAM then copies nonvolatile data; unlimited.
// [R21] Software save inhibited while supply is below threshold.
// [R22] Power-up restore finishes within 650 us of supply rising.
// [R23] Started nonvolatile cycle completes alone, ignoring bus inputs.
// [R24] Never issue the reserved test sequence ending in 139C.
// [R25] Aborted sequence returns tracker to idle; 0000 restarts it.
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl
  import nv_host_pkg::*;
#(
  parameter int SAVE_CYC  = SAVE_CYC_DEF,
  parameter int PWRUP_CYC = PWRUP_CYC_DEF
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // Supply sense from the board
  input  wire logic              PWR_GOOD,
  // Command port
  input  wire logic              CMD_VALID,
  input  wire cmd_t              CMD,
  output var  logic              CMD_READY,
  output var  logic              RSP_VALID,
  output var  logic [DATA_W-1:0] RSP_RDATA,
  output var  logic              BUSY,
  // Memory pins
  output var  logic              MEM_CE_N,
  output var  logic              MEM_OE_N,
  output var  logic              MEM_WE_N,
  output var  logic [ADDR_W-1:0] MEM_ADDR,
  input  wire logic [DATA_W-1:0] DQ_IN,
  output var  logic [DATA_W-1:0] DQ_OUT,
  output var  logic              DQ_OE_N
);

  if (SAVE_CYC < 1 || SAVE_CYC >= 2**CNT_W) begin : g_chk_save
    $error("SAVE_CYC out of counter range");
  end
  if (PWRUP_CYC < 1 || PWRUP_CYC >= 2**CNT_W) begin : g_chk_pwr
    $error("PWRUP_CYC out of counter range");
  end

  localparam logic [CNT_W-1:0] RD_LD      = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LD      = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] SEQ_LD     = CNT_W'(SEQ_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LD     = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] RESTORE_LD = CNT_W'(RESTORE_CYC - 1);
  localparam logic [CNT_W-1:0] SAVE_LD    = CNT_W'(SAVE_CYC - 1);
  localparam logic [CNT_W-1:0] PWRUP_LD   = CNT_W'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = '0;

  state_t            state;
  state_t            next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [2:0]        step;
  logic              nv_op;
  logic              restore;
  logic              pwr_meta;
  logic              pwr_sync;
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic              accept;
  logic              cnt_done;

  // Step address; the test ending is never produced
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                 input logic       rcl);
    unique case (idx)
      3'h0:    seq_addr = SEQ_P0; // R15
      3'h1:    seq_addr = SEQ_P1;
      3'h2:    seq_addr = SEQ_P2;
      3'h3:    seq_addr = SEQ_P3;
      3'h4:    seq_addr = SEQ_P4;
      default: seq_addr = rcl ? SEQ_RESTORE : SEQ_SAVE; // R17 R24
    endcase
  endfunction

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
      dq_meta  <= DATA_RST;
      dq_sync  <= DATA_RST;
    end else begin
      pwr_meta <= PWR_GOOD;
      pwr_sync <= pwr_meta;
      dq_meta  <= DQ_IN;
      dq_sync  <= dq_meta;
    end
  end

  assign cnt_done = (cnt == CNT_ZERO);
  // Low supply refuses every command, software save included
  assign accept = (state == ST_IDLE) && CMD_VALID && CMD_READY
                  && pwr_sync; // R21

  always_comb begin
    next_state = state;
    next_cnt   = cnt_done ? cnt : cnt - CNT_W'(1);
    if (!pwr_sync) begin
      // Device runs its own save; wait out the power-up restore later
      next_state = ST_POWERUP; // R13
      next_cnt   = PWRUP_LD;
    end else begin
      unique case (state)
        ST_POWERUP: begin
          if (cnt_done) begin
            next_state = ST_IDLE; // R22
          end
        end
        ST_IDLE: begin
          if (accept) begin
            unique case (CMD.op)
              OP_READ: begin
                next_state = ST_READ;
                next_cnt   = RD_LD;
              end
              OP_WRITE: begin
                next_state = ST_WRITE;
                next_cnt   = WR_LD;
              end
              default: begin
                next_state = ST_UNLOCK;
                next_cnt   = SEQ_LD;
              end
            endcase
          end
        end
        ST_READ, ST_WRITE, ST_UNLOCK: begin
          if (cnt_done) begin
            next_state = ST_GAP;
            next_cnt   = GAP_LD;
          end
        end
        ST_GAP: begin
          if (cnt_done) begin
            if (nv_op && step == SEQ_LAST) begin
              next_state = ST_NV_WAIT; // R18
              next_cnt   = restore ? RESTORE_LD : SAVE_LD;
            end else if (nv_op) begin
              next_state = ST_UNLOCK; // R16
              next_cnt   = SEQ_LD;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_NV_WAIT: begin
          // Bus left idle until the cycle has surely finished
          if (cnt_done) begin
            next_state = ST_IDLE; // R23
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_cnt   = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= ST_POWERUP;
      cnt   <= PWRUP_LD;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Sequence tracking; a power loss drops partial progress
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      step    <= 3'h0;
      nv_op   <= 1'b0;
      restore <= 1'b0;
    end else if (accept) begin
      step    <= 3'h0;
      nv_op   <= (CMD.op == OP_SAVE) || (CMD.op == OP_RESTORE);
      restore <= (CMD.op == OP_RESTORE); // R3
    end else if (next_state == ST_IDLE || next_state == ST_POWERUP) begin
      step  <= 3'h0; // R25
      nv_op <= 1'b0;
    end else if (state == ST_GAP && cnt_done && nv_op && step != SEQ_LAST) begin
      step <= step + 3'h1;
    end
  end

  // Address changes on the same edge that drives chip select low
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MEM_ADDR <= ADDR_RST;
    end else if (accept) begin
      MEM_ADDR <= (CMD.op == OP_READ || CMD.op == OP_WRITE) ? CMD.addr
                                                            : SEQ_P0;
    end else if (state == ST_GAP && cnt_done && nv_op && step != SEQ_LAST) begin
      MEM_ADDR <= seq_addr(step + 3'h1, restore); // R15
    end
  end

  // Strobes from the next state so pins line up with the state
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MEM_CE_N <= 1'b1;
      MEM_OE_N <= 1'b1;
      MEM_WE_N <= 1'b1;
      DQ_OE_N  <= 1'b1;
    end else begin
      MEM_CE_N <= !(next_state == ST_READ || next_state == ST_WRITE
                    || next_state == ST_UNLOCK); // R4
      // Unlock reads keep output enable high to spare the bus
      MEM_OE_N <= (next_state != ST_READ); // R2 R5 R9
      MEM_WE_N <= (next_state != ST_WRITE); // R1 R14
      // Data held one cycle past the rising strobes
      // A power drop mid-write releases the data lines at once
      DQ_OE_N  <= !(next_state == ST_WRITE
                    || (state == ST_WRITE && next_state == ST_GAP)); // R7
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      DQ_OUT <= DATA_RST;
    end else if (accept && CMD.op == OP_WRITE) begin
      DQ_OUT <= CMD.wdata;
    end
  end

  // Read data taken once access time plus sync delay has passed
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= DATA_RST;
    end else begin
      RSP_VALID <= (state == ST_READ) && cnt_done && pwr_sync;
      if (state == ST_READ && cnt_done) begin
        RSP_RDATA <= dq_sync; // R6
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CMD_READY <= 1'b0;
      BUSY      <= 1'b1;
    end else begin
      CMD_READY <= (next_state == ST_IDLE);
      BUSY      <= (next_state != ST_IDLE);
    end
  end

  a_unlock_we_high: assert property (@(posedge REF_CLK) disable iff (RST) // R1
    nv_op && !MEM_CE_N |-> MEM_WE_N && MEM_OE_N)
    else $error("write or output strobe low during unlock step");
  a_sixth_addr: assert property (@(posedge REF_CLK) disable iff (RST) // R3
    state == ST_UNLOCK && step == SEQ_LAST
    |-> MEM_ADDR == (restore ? SEQ_RESTORE : SEQ_SAVE))
    else $error("sixth unlock address wrong");
  a_step_pulse: assert property (@(posedge REF_CLK) disable iff (RST) // R4
    $fell(MEM_CE_N) && nv_op && pwr_sync |-> !MEM_CE_N [*4] ##1 MEM_CE_N)
    else $error("unlock chip select pulse length wrong");
  a_read_strobes: assert property (@(posedge REF_CLK) disable iff (RST) // R5
    state == ST_READ |-> !MEM_CE_N && !MEM_OE_N && MEM_WE_N && DQ_OE_N)
    else $error("read strobes wrong");
  a_write_addr_stable: assert property (@(posedge REF_CLK) disable iff (RST) // R7
    !MEM_WE_N ##1 !MEM_WE_N |-> $stable(MEM_ADDR) && !DQ_OE_N)
    else $error("address or data moved during write");
  a_write_oe_high: assert property (@(posedge REF_CLK) disable iff (RST) // R9
    !MEM_WE_N || !DQ_OE_N |-> MEM_OE_N)
    else $error("output enable low during write");
  a_powerup_quiet: assert property (@(posedge REF_CLK) disable iff (RST) // R14
    state == ST_POWERUP |-> MEM_WE_N && MEM_CE_N && DQ_OE_N)
    else $error("bus active during power-up");
  a_seq_order: assert property (@(posedge REF_CLK) disable iff (RST) // R15
    state == ST_UNLOCK |-> MEM_ADDR == seq_addr(step, restore))
    else $error("unlock address out of order");
  a_nv_disabled: assert property (@(posedge REF_CLK) disable iff (RST) // R18
    state == ST_NV_WAIT |-> MEM_CE_N && MEM_WE_N && !CMD_READY)
    else $error("bus used during nonvolatile cycle");
  a_no_low_supply: assert property (@(posedge REF_CLK) disable iff (RST) // R21
    !pwr_sync |=> !accept)
    else $error("command taken under low supply");
  a_no_test_addr: assert property (@(posedge REF_CLK) disable iff (RST) // R24
    !MEM_CE_N |-> MEM_ADDR != SEQ_TEST)
    else $error("reserved test address issued");
  a_read_answer: assert property (@(posedge REF_CLK) disable iff (RST) // R6
    accept && CMD.op == OP_READ ##1 pwr_sync [*7] |-> ##1 RSP_VALID)
    else $error("read answer late");

  c_read: cover property (@(posedge REF_CLK) disable iff (RST) RSP_VALID);
  c_write: cover property (@(posedge REF_CLK) disable iff (RST)
    $rose(MEM_WE_N) && !nv_op);
  c_save: cover property (@(posedge REF_CLK) disable iff (RST)
    state == ST_NV_WAIT && !restore);
  c_restore: cover property (@(posedge REF_CLK) disable iff (RST)
    state == ST_NV_WAIT && restore);

endmodule
`default_nettype wire

/* File: test/nv_sram_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nv_sram_model
  import nv_host_pkg::*;
#(
  parameter int SAVE_NS = 150,
  parameter int RCL_NS  = 200
) (
  // Strobes and supply
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              pwr_good,
  // Address and data
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] host_dq,
  input  wire logic              host_oe_n,
  output logic      [DATA_W-1:0] dq,
  output logic                   clash
);
  localparam logic [ADDR_W-1:0] SEQ [5] = '{SEQ_P0, SEQ_P1, SEQ_P2,
                                            SEQ_P3, SEQ_P4};
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] nv  [2**ADDR_W];
  logic [DATA_W-1:0] held    = 8'h00;
  logic              busy    = 1'b0;
  logic              dirty   = 1'b0;
  logic              wr_on   = 1'b0;
  logic              rcl_req = 1'b1;
  int                step    = 0;
  int                saves   = 0;
  int                rcls    = 0;
  logic              drv;

  initial foreach (nv[i]) nv[i] = 8'h5A ^ DATA_W'(i);

  // Blocking delay keeps the chip deaf to bus strobes until the cycle ends; supply edges still start cycles
  task automatic nv_cycle(input logic save);
    busy = 1'b1;
    if (save) begin
      foreach (nv[i]) nv[i] = 8'hFF;
      foreach (nv[i]) nv[i] = mem[i];
      saves++;
      #(SAVE_NS);
    end else begin
      foreach (mem[i]) mem[i] = 8'h00;
      foreach (mem[i]) mem[i] = nv[i];
      rcls++;
      #(RCL_NS);
    end
    dirty = 1'b0;
    step  = 0;
    busy  = 1'b0;
  endtask

  always @(ce_n or we_n)
    if (!ce_n && !we_n && !busy && pwr_good) wr_on = 1'b1;
  always @(posedge ce_n or posedge we_n)
    if (wr_on) begin
      mem[addr] = host_dq;
      wr_on = 1'b0;
      dirty = 1'b1;
      step  = 0;
    end

  // Sampled just after the select edge so the address has settled
  always @(negedge ce_n) begin
    #1;
    if (we_n && !busy && pwr_good) begin
      if (step == 5 && addr == SEQ_SAVE) nv_cycle(1'b1);
      else if (step == 5 && addr == SEQ_RESTORE) nv_cycle(1'b0);
      else if (step < 5 && addr == SEQ[step]) step++;
      else step = int'(addr == SEQ_P0);
    end
  end

  always @(negedge pwr_good) begin
    rcl_req = 1'b1;
    if (dirty) nv_cycle(1'b1);
  end
  always @(posedge pwr_good)
    if (rcl_req) begin
      rcl_req = 1'b0;
      nv_cycle(1'b0);
    end

  assign drv = !ce_n && !oe_n && we_n && !busy && pwr_good;
  always @* if (drv) held = mem[addr];
  // Released lines show the inverse of the last byte, never a stale copy
  assign dq    = !host_oe_n ? host_dq : drv ? mem[addr] : ~held;
  assign clash = drv && !host_oe_n;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import nv_host_pkg::*;
  logic              clk = 1'b0;
  logic              rst, pwr_good, cmd_valid, cmd_ready, rsp_valid, busy;
  logic              ce_n, oe_n, we_n, dq_oe_n, clash, wr_seen;
  cmd_t              cmd;
  logic [DATA_W-1:0] rsp_rdata, dq_in, dq_out;
  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] seen [$];
  int                err_count = 0;
  int                compares  = 0;

  always #(CLK_NS / 2) clk = ~clk;

  nv_host_ctrl #(.SAVE_CYC(20), .PWRUP_CYC(30)) dut (
    .REF_CLK(clk), .RST(rst), .PWR_GOOD(pwr_good), .CMD_VALID(cmd_valid),
    .CMD(cmd), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .BUSY(busy), .MEM_CE_N(ce_n), .MEM_OE_N(oe_n),
    .MEM_WE_N(we_n), .MEM_ADDR(mem_addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n));

  nv_sram_model mdl (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .pwr_good(pwr_good),
    .addr(mem_addr), .host_dq(dq_out), .host_oe_n(dq_oe_n), .dq(dq_in),
    .clash(clash));

  always @(negedge ce_n) begin
    #2;
    seen.push_back(mem_addr);
    if (!we_n) wr_seen = 1'b1;
  end
  always @(negedge clk)
    if (rst === 1'b0 && clash !== 1'b0) `CHK("clash", 1'b0, clash)

  task automatic close_out;
    $display("Compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic idle;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    `CHK("ready", 1'b1, cmd_ready)
  endtask

  task automatic issue(input op_t op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    idle();
    cmd = '{op: op, addr: a, wdata: d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic rd_check(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e);
    int k;
    issue(OP_READ, a, 8'h00);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 20);
    `CHK("rd_lat", RD_CYC, k)
    `CHK("rd_data", e, rsp_rdata)
    @(negedge clk);
  endtask

  task automatic chk_seq(input logic [ADDR_W-1:0] last);
    logic [ADDR_W-1:0] ex [6];
    ex = '{SEQ_P0, SEQ_P1, SEQ_P2, SEQ_P3, SEQ_P4, last};
    `CHK("seq_len", 6, seen.size())
    foreach (ex[i]) if (i < seen.size()) `CHK("seq_addr", ex[i], seen[i])
    `CHK("seq_we", 1'b0, wr_seen)
  endtask

  task automatic t_powerup;
    rd_check(13'h0010, 8'h4A);
    `CHK("rcl_up", 1, mdl.rcls)
  endtask

  task automatic t_rw;
    issue(OP_WRITE, 13'h0000, 8'hC3);
    issue(OP_WRITE, 13'h1FFF, 8'h3C);
    issue(OP_WRITE, 13'h0000, 8'h96);
    rd_check(13'h0000, 8'h96);
    rd_check(13'h1FFF, 8'h3C);
  endtask

  task automatic t_save;
    int s;
    s = mdl.saves;
    seen.delete();
    wr_seen = 1'b0;
    issue(OP_SAVE, 13'h0000, 8'h00);
    idle();
    chk_seq(SEQ_SAVE);
    `CHK("nv_data", 8'h96, mdl.nv[0])
    issue(OP_SAVE, 13'h0000, 8'h00);
    idle();
    `CHK("saves", s + 2, mdl.saves)
  endtask

  task automatic t_restore;
    issue(OP_WRITE, 13'h0000, 8'h11);
    seen.delete();
    wr_seen = 1'b0;
    issue(OP_RESTORE, 13'h0000, 8'h00);
    idle();
    chk_seq(SEQ_RESTORE);
    rd_check(13'h0000, 8'h96);
  endtask

  task automatic t_power;
    int s;
    int r;
    issue(OP_WRITE, 13'h0042, 8'hA5);
    idle();
    s = mdl.saves;
    r = mdl.rcls;
    pwr_good = 1'b0;
    repeat (40) @(negedge clk);
    `CHK("auto_save", s + 1, mdl.saves)
    `CHK("ready_low", 1'b0, cmd_ready)
    `CHK("busy_low", 1'b1, busy)
    pwr_good = 1'b1;
    rd_check(13'h0042, 8'hA5);
    `CHK("rcl_cnt", r + 1, mdl.rcls)
    `CHK("we_idle", 1'b1, we_n)
    pwr_good = 1'b0;
    repeat (40) @(negedge clk);
    `CHK("no_save", s + 1, mdl.saves)
    pwr_good = 1'b1;
    idle();
  endtask

  initial begin
    #300000;
    err_count++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    pwr_good = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_seen = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    pwr_good = 1'b1;
    t_powerup();
    t_rw();
    t_save();
    t_restore();
    t_power();
    close_out();
  end
endmodule
`default_nettype wire
